// >>> testbench/gate_port_monitor.sv
// assertion checker bound to the gate driver serial register port
`timescale 1ns/1ps

module gate_port_monitor
	import gate_port_pkg::*;
#(
	parameter bit          HIGH_TEMP_GRADE = 1'b0,
	parameter int unsigned SUPERV_CYC_0    = 32'd2500000,
	parameter int unsigned SUPERV_CYC_1    = 32'd5000000,
	parameter int unsigned SUPERV_CYC_2    = 32'd12500000,
	parameter int unsigned SUPERV_CYC_3    = 32'd25000000
) (
	// clock and reset
	input wire logic                 sys_clk,
	input wire logic                 rst,
	// serial pins
	input wire logic                 serial_clk,
	input wire logic                 chip_select_n,
	input wire logic                 serial_in,
	input wire logic                 serial_out,
	input wire logic                 serial_out_en_n,
	// state, status and settings
	input wire logic                 operating,
	input wire logic                 sleep_enter,
	input wire gate_port_pkg::status_in_t status_in,
	input wire gate_port_pkg::control_t   control,
	input wire logic                 supervision_restart,
	input wire logic                 supervision_fault,
	input wire logic                 frame_error
);
	// everything is judged on the system clock
	default clocking mon_cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);

	a_out_released: assert property (
		serial_out_en_n == chip_select_n) else $error("reply line not released");
	a_ctrl_hold: assert property (
		!chip_select_n && !$past(chip_select_n, 3) && !$past(sleep_enter)
		|-> $stable({control.high_side_drive, control.low_side_drive,
		control.drain_sense})) else $error("setting changed inside frame");
	a_sleep_defaults: assert property (
		sleep_enter |=> control.high_side_drive == RST_HS_DRV
		&& control.low_side_drive == RST_LS_DRV
		&& control.drain_sense == RST_DRAIN_SET) else $error("no default");
	a_chip_op_default: assert property (
		sleep_enter |=> control.chip_operation == {HIGH_TEMP_GRADE, 10'h000})
		else $error("chip operation default wrong");
	a_err_idle: assert property (
		frame_error |-> chip_select_n && $past(chip_select_n, 1) ##1 !frame_error)
		else $error("frame error misplaced");
	a_restart_idle: assert property (
		supervision_restart |-> chip_select_n ##1 !supervision_restart)
		else $error("restart misplaced");
	a_mode_guard: assert property (
		operating && $past(operating) && $changed(control.drain_sense[2:0])
		|-> control.drain_sense[2:0] == MODE_DISABLED
		&& $past(control.drain_sense[2:1]) == 2'b00)
		else $error("illegal mode change while running");
	a_fault_latched: assert property (
		$fell(supervision_fault) |-> chip_select_n && $past(chip_select_n, 2))
		else $error("fault dropped without clear");
endmodule : gate_port_monitor

// >>> testbench/gate_port_tb.sv
// self-checking bench for the gate driver serial register port
`timescale 1ns/1ps

module gate_port_tb;
	import gate_port_pkg::*;

	logic        sys_clk;
	logic        rst;
	wire         serial_clk;
	wire         chip_select_n;
	wire         serial_in;
	wire         sdo;
	logic        serial_out;
	logic        serial_out_en_n;
	logic        operating;
	logic        sleep_enter;
	status_in_t  status_in;
	control_t    control;
	logic        supervision_restart;
	logic        supervision_fault;
	logic        frame_error;
	logic [15:0] r;
	int          n_mismatch = 0;
	int          num_checks = 0;
	int          n_err      = 0;
	int          n_rst      = 0;
	int          cyc        = 0;

	// reply wire floats while the port is deselected
	assign sdo = serial_out_en_n ? 1'bz : serial_out;

	// short supervision intervals keep the run brief
	gate_port #(.SUPERV_CYC_0(400), .SUPERV_CYC_1(800),
		.SUPERV_CYC_2(1600), .SUPERV_CYC_3(3200)) u_dut (
		.sys_clk, .rst, .serial_clk, .chip_select_n, .serial_in,
		.serial_out, .serial_out_en_n, .operating, .sleep_enter,
		.status_in, .control, .supervision_restart,
		.supervision_fault, .frame_error);
	spi_master_model u_mst (.serial_clk, .chip_select_n, .serial_in, .sdo);

	// 250 MHz system clock
	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end

	// pulse counters and hang guard
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (frame_error === 1'b1) n_err <= n_err + 1;
		if (supervision_restart === 1'b1) n_rst <= n_rst + 1;
		if (cyc == 30000) begin
			n_mismatch++;
			tally_and_finish();
		end
	end

	task automatic tally_and_finish();
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : tally_and_finish

	task automatic chk(input logic [10:0] g, input logic [10:0] e);
		num_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("wrong value t=%0t got %h exp %h", $time, g, e);
		end
	endtask : chk

	task automatic acc(input logic rd, input logic [3:0] a,
		input logic [10:0] d, output logic [10:0] q);
		u_mst.xfer({rd, a, d}, 16, r);
		q = r[10:0];
	endtask : acc

	task automatic t_defaults();
		logic [10:0] q;
		for (int a = 1; a < 13; a++) begin
			acc(1'b1, 4'(a), 11'h000, q);
			chk(q, (a == 5) ? RST_HS_DRV : (a == 6) ? RST_LS_DRV : 11'h000);
		end
	endtask : t_defaults

	task automatic t_run();
		logic [10:0] q;
		@(negedge sys_clk);
		operating = 1'b1;
		acc(1'b0, ADDR_HS_DRV, 11'h2a5, q);
		chk(q, RST_HS_DRV);
		acc(1'b0, ADDR_LS_DRV, 11'h15a, q);
		acc(1'b1, ADDR_HS_DRV, 11'h000, q);
		chk(q, 11'h2a5);
		chk(control.low_side_drive, 11'h15a);
		acc(1'b0, ADDR_DRAIN_SET, 11'h0f8, q);
		acc(1'b1, ADDR_DRAIN_SET, 11'h000, q);
		chk(q, 11'h0f8);
	endtask : t_run

	// entries: running, mode written, mode expected
	task automatic t_mode();
		logic [6:0]  tbl [6];
		logic [10:0] q;
		tbl = '{7'h48, 7'h52, 7'h42, 7'h09, 7'h41, 7'h52};
		foreach (tbl[i]) begin
			@(negedge sys_clk);
			operating = tbl[i][6];
			acc(1'b0, ADDR_DRAIN_SET, {8'h00, tbl[i][5:3]}, q);
			acc(1'b1, ADDR_DRAIN_SET, 11'h000, q);
			chk(q, {8'h00, tbl[i][2:0]});
		end
		@(negedge sys_clk);
		operating = 1'b0;
	endtask : t_mode

	task automatic t_ro();
		logic [3:0]  ro [5];
		logic [10:0] q;
		ro = '{ADDR_WARN, ADDR_DRAIN, ADDR_CHIP, ADDR_GATE, ADDR_UNUSED};
		foreach (ro[i]) begin
			acc(1'b0, ro[i], 11'h7ff, q);
			chk(q, 11'h000);
			acc(1'b1, ro[i], 11'h000, q);
			chk(q, 11'h000);
		end
	endtask : t_ro

	task automatic t_frame_err();
		int          len [2];
		logic [10:0] q;
		len = '{15, 17};
		foreach (len[i]) begin
			u_mst.xfer({1'b0, ADDR_TIMING, 11'h3c3}, len[i], r);
			acc(1'b1, ADDR_TIMING, 11'h000, q);
			chk(q, RST_TIMING);
		end
		chk(11'(n_err), 11'h002);
		acc(1'b0, ADDR_TIMING, 11'h3c3, q);
		acc(1'b1, ADDR_TIMING, 11'h000, q);
		chk(q, 11'h3c3);
	endtask : t_frame_err

	// each disable bit against the status place it silences
	task automatic t_status();
		logic [10:0] cv [7];
		logic [3:0]  av [7];
		logic [10:0] ev [7];
		logic [10:0] q;
		cv = '{11'h000, 11'h000, 11'h000, 11'h010, 11'h100, 11'h200, 11'h400};
		av = '{4'h2, 4'h3, 4'h4, 4'h2, 4'h4, 4'h3, 4'h3};
		ev = '{11'h425, 11'h500, 11'h7e0, 11'h420, 11'h000, 11'h100, 11'h400};
		@(negedge sys_clk);
		status_in = '{warn: 11'h10f, drain_oc: 6'h21, sense_oc: 3'h5,
			chip: 11'h500, gate_fault: 6'h3f};
		repeat (4) @(negedge sys_clk);
		acc(1'b1, ADDR_WARN, 11'h000, q);
		chk(q, 11'h52f);
		foreach (cv[i]) begin
			acc(1'b0, ADDR_CHIP_OP, cv[i], q);
			acc(1'b1, av[i], 11'h000, q);
			chk(q, ev[i]);
		end
		acc(1'b0, ADDR_CHIP_OP, 11'h000, q);
		@(negedge sys_clk);
		status_in = '0;
		repeat (4) @(negedge sys_clk);
	endtask : t_status

	task automatic t_superv();
		logic [10:0] q;
		int          k;
		acc(1'b0, ADDR_CHIP_OP, 11'h008, q);
		k = n_rst;
		repeat (3) acc(1'b1, ADDR_WARN, 11'h000, q);
		chk(11'(n_rst - k), 11'h003);
		repeat (200) @(negedge sys_clk);
		chk({10'h000, supervision_fault}, 11'h000);
		repeat (150) @(negedge sys_clk);
		chk({10'h000, supervision_fault}, 11'h001);
		acc(1'b1, ADDR_CHIP, 11'h000, q);
		chk(q, 11'h200);
		acc(1'b0, ADDR_CHIP_OP, 11'h002, q);
		chk(q, 11'h000);
		chk({10'h000, supervision_fault}, 11'h000);
		// delay code 1 doubles the interval to 800 cycles
		acc(1'b0, ADDR_CHIP_OP, 11'h028, q);
		repeat (500) @(negedge sys_clk);
		chk({10'h000, supervision_fault}, 11'h000);
		repeat (250) @(negedge sys_clk);
		chk({10'h000, supervision_fault}, 11'h001);
	endtask : t_superv

	task automatic t_sleep();
		logic [10:0] q;
		@(negedge sys_clk);
		sleep_enter = 1'b1;
		@(negedge sys_clk);
		sleep_enter = 1'b0;
		chk(control.high_side_drive, RST_HS_DRV);
		acc(1'b1, ADDR_TIMING, 11'h000, q);
		chk(q, RST_TIMING);
	endtask : t_sleep

	// reset, then the scenarios in turn
	initial begin
		rst         = 1'b1;
		operating   = 1'b0;
		sleep_enter = 1'b0;
		status_in   = '0;
		repeat (10) @(posedge sys_clk);
		@(negedge sys_clk);
		rst = 1'b0;
		repeat (4) @(negedge sys_clk);
		t_defaults();
		t_run();
		t_mode();
		t_ro();
		t_frame_err();
		t_status();
		t_superv();
		t_sleep();
		tally_and_finish();
	end
endmodule : gate_port_tb

bind gate_port gate_port_monitor #(.HIGH_TEMP_GRADE(HIGH_TEMP_GRADE),
	.SUPERV_CYC_0(SUPERV_CYC_0), .SUPERV_CYC_1(SUPERV_CYC_1),
	.SUPERV_CYC_2(SUPERV_CYC_2), .SUPERV_CYC_3(SUPERV_CYC_3)) u_mon (
	.sys_clk, .rst, .serial_clk, .chip_select_n, .serial_in, .serial_out,
	.serial_out_en_n, .operating, .sleep_enter, .status_in, .control,
	.supervision_restart, .supervision_fault, .frame_error);

// >>> testbench/spi_master_model.sv
// serial bus master model driving frames into the register port
`timescale 1ns/1ps

module spi_master_model (
	// link pins
	output logic      serial_clk,
	output logic      chip_select_n,
	output logic      serial_in,
	input  wire logic sdo
);
	// idle levels; the clock stands still between frames
	initial begin
		serial_clk    = 1'b0;
		chip_select_n = 1'b1;
		serial_in     = 1'b0;
	end

	// one frame of n clocks at 6 ns, reply taken on falling edges
	task automatic xfer(input logic [15:0] w, input int n,
		output logic [15:0] r);
		r = 16'h0000;
		chip_select_n = 1'b0;
		#3;
		for (int i = 0; i < n; i++) begin
			serial_clk = 1'b1;
			serial_in  = (i < 16) ? w[15 - i] : 1'b0;
			#3;
			serial_clk = 1'b0;
			r          = {r[14:0], sdo};
			#3;
		end
		chip_select_n = 1'b1;
		// no stale bit left on the idle line
		serial_in = ~serial_in;
		#500;
	endtask : xfer
endmodule : spi_master_model

// >>> verilog/gate_port.sv
// gate driver serial slave port with status and control register map
`timescale 1ns/1ps

module gate_port #(
	parameter bit          HIGH_TEMP_GRADE = 1'b0,
	parameter int unsigned SUPERV_CYC_0    = 32'd2500000,
	parameter int unsigned SUPERV_CYC_1    = 32'd5000000,
	parameter int unsigned SUPERV_CYC_2    = 32'd12500000,
	parameter int unsigned SUPERV_CYC_3    = 32'd25000000
) (
	// system clock and reset
	input  wire logic                 sys_clk,
	input  wire logic                 rst,
	// serial link pins
	input  wire logic                 serial_clk,
	input  wire logic                 chip_select_n,
	input  wire logic                 serial_in,
	output logic                      serial_out,
	output logic                      serial_out_en_n,
	// device state from the mode logic
	input  wire logic                 operating,
	input  wire logic                 sleep_enter,
	// monitor levels from the analog side
	input  gate_port_pkg::status_in_t status_in,
	// settings and events
	output gate_port_pkg::control_t   control,
	output logic                      supervision_restart,
	output logic                      supervision_fault,
	output logic                      frame_error
);
	import gate_port_pkg::*;

	// hot grade starts with thermal shutdown off
	localparam logic [10:0] CHIP_OP_DEFAULT =
		RST_CHIP_OP | (11'(HIGH_TEMP_GRADE) << THERMAL_OFF_BIT);

	// saturating frame bit counter
	function automatic logic [4:0] count_up(input logic [4:0] c);
		count_up = (c == COUNT_MAX) ? c : c + 5'h01;
	endfunction : count_up

	// only the control addresses take writes
	function automatic logic writable(input logic [3:0] a);
		writable = (a == ADDR_HS_DRV) || (a == ADDR_LS_DRV) ||
			(a == ADDR_TIMING) || (a == ADDR_CHIP_OP) ||
			(a == ADDR_AMP) || (a == ADDR_REGUL) || (a == ADDR_DRAIN_SET);
	endfunction : writable

	// supervision interval chosen by the two delay bits
	function automatic logic [31:0] interval(input logic [1:0] sel);
		unique case (sel)
			2'h0: interval = 32'(SUPERV_CYC_0);
			2'h1: interval = 32'(SUPERV_CYC_1);
			2'h2: interval = 32'(SUPERV_CYC_2);
			2'h3: interval = 32'(SUPERV_CYC_3);
		endcase
	endfunction : interval

	// link side state
	logic        in_frame_q;
	logic        tx_active_q;
	logic [4:0]  rx_count_q;
	logic [15:0] rx_shift_q;
	logic [10:0] tx_shift_q;
	logic        out_q;
	logic [10:0] reply_word;
	logic        tx_load;

	// system side state
	logic        cs_meta_q, cs_sync_q, cs_prev_q;
	status_in_t  stat_meta_q, stat_sync_q, snap_q;
	logic [10:0] hs_q, ls_q, timing_q, op_q, amp_q, regul_q, drain_q;
	logic [10:0] op_d, drain_d;
	logic [31:0] timer_q;
	logic        superv_fault_q, restart_q, frame_err_q;
	logic [10:0] view [16];
	logic [10:0] view_q [16];

	// frame decode on the system side
	logic        frame_done, frame_ok, cmd_read, write_ok, wr_op;
	logic [3:0]  cmd_addr;
	logic [10:0] cmd_data;
	logic        superv_on, superv_expire, superv_clear, restart_hit;
	logic [31:0] superv_limit;
	logic [2:0]  new_mode, old_mode;
	logic        mode_change_ok;
	logic [10:0] warn_word, drain_word, chip_word, gate_word;
	logic        any_fault;

	// output released while select is high
	assign serial_out_en_n = chip_select_n;
	assign serial_out      = out_q;

	// in_frame set by the first falling edge after select fell; cleared whenever select high
	// select high holds off the link logic
	always_ff @(negedge serial_clk or posedge rst or
		posedge chip_select_n) begin
		if (rst || chip_select_n) begin
			in_frame_q <= 1'b0;
		end else begin
			in_frame_q <= 1'b1;
		end
	end

	// count and word survive select rising so the system side can read them
	// sample on falling edge, msb first
	always_ff @(negedge serial_clk or posedge rst) begin
		if (rst) begin
			rx_count_q <= 5'h00;
			rx_shift_q <= 16'h0000;
		end else if (!chip_select_n) begin
			rx_count_q <= in_frame_q ? count_up(rx_count_q) : 5'h01;
			rx_shift_q <= {rx_shift_q[14:0], serial_in};
		end
	end

	// reply word chosen once the address is in, before the sixth rising edge
	// current contents, whatever the command
	// limitation: the sixth rising edge must follow select by 4 sys_clk
	assign reply_word = view_q[rx_shift_q[3:0]];
	assign tx_load    = in_frame_q && (rx_count_q == HEAD_BITS);

	// launch on rising edge; header bits go out as zero
	// relies on clock low at select edges for a clean first edge
	always_ff @(posedge serial_clk or posedge rst) begin
		if (rst) begin
			out_q       <= 1'b0;
			tx_shift_q  <= 11'h000;
			tx_active_q <= 1'b0;
		end else if (tx_load) begin
			out_q       <= reply_word[10];
			tx_shift_q  <= {reply_word[9:0], 1'b0};
			tx_active_q <= 1'b1;
		end else begin
			out_q       <= tx_active_q && in_frame_q && tx_shift_q[10];
			tx_shift_q  <= {tx_shift_q[9:0], 1'b0};
			tx_active_q <= tx_active_q && in_frame_q;
		end
	end

	// select synchroniser; only the second stage and its delayed copy are looked at
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cs_meta_q <= 1'b1;
			cs_sync_q <= 1'b1;
			cs_prev_q <= 1'b1;
		end else begin
			cs_meta_q <= chip_select_n;
			cs_sync_q <= cs_meta_q;
			cs_prev_q <= cs_sync_q;
		end
	end

	// monitor synchroniser and a snapshot frozen while a frame runs,
	// so the link side reads a steady word across the clock boundary
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			stat_meta_q <= '0;
			stat_sync_q <= '0;
			snap_q      <= '0;
		end else begin
			stat_meta_q <= status_in;
			stat_sync_q <= stat_meta_q;
			if (cs_sync_q) begin
				snap_q <= stat_sync_q;
			end
		end
	end

	// frozen copy of the read view for the link side; it only moves while
	// select is high, so a reply never mixes bits from two system cycles
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			view_q <= '{default: 11'h000};
		end else if (cs_sync_q) begin
			view_q <= view;
		end
	end

	// frame end; link registers are quiet by now since the clock is stopped
	assign frame_done = cs_sync_q && !cs_prev_q;
	// exactly sixteen clocks or the frame is dropped
	assign frame_ok   = frame_done && (rx_count_q == FRAME_BITS);
	// fixed field split of the word
	assign cmd_read   = rx_shift_q[RW_BIT];
	assign cmd_addr   = rx_shift_q[ADDR_HI:ADDR_LO];
	assign cmd_data   = rx_shift_q[DATA_W-1:0];
	// only control addresses, only after a good frame
	assign write_ok   = frame_ok && !cmd_read && writable(cmd_addr);
	assign wr_op      = write_ok && (cmd_addr == ADDR_CHIP_OP);

	// reading 0x1 restarts the supervision timer
	assign restart_hit   = frame_ok && cmd_read && (cmd_addr == ADDR_WARN);
	assign superv_on     = op_q[SUPERV_ON_BIT];
	assign superv_limit  = interval(op_q[SUPERV_DLY_HI:SUPERV_DLY_LO]) -
		32'h1;
	assign superv_expire = superv_on && !restart_hit &&
		(timer_q >= superv_limit);
	assign superv_clear  = wr_op && cmd_data[FAULT_CLR_BIT];

	// only latched or report to disabled while running
	assign new_mode       = cmd_data[MODE_HI:0];
	assign old_mode       = drain_q[MODE_HI:0];
	assign mode_change_ok = !operating || (new_mode == old_mode) ||
		((new_mode == MODE_DISABLED) &&
		 ((old_mode == MODE_LATCHED) || (old_mode == MODE_REPORT)));
	assign drain_d = mode_change_ok ? cmd_data :
		{cmd_data[10:MODE_HI+1], old_mode};

	// expiry drops the timer enable; it must be set again to rearm
	assign op_d = wr_op ? cmd_data : op_q;

	// settings registers
	// defaults at reset and on sleep entry; reads never clear them
	// drive currents are plain writes, usable while running
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			hs_q     <= RST_HS_DRV;
			ls_q     <= RST_LS_DRV;
			timing_q <= RST_TIMING;
			op_q     <= CHIP_OP_DEFAULT;
			amp_q    <= RST_AMP;
			regul_q  <= RST_REGUL;
			drain_q  <= RST_DRAIN_SET;
		end else if (sleep_enter) begin
			hs_q     <= RST_HS_DRV;
			ls_q     <= RST_LS_DRV;
			timing_q <= RST_TIMING;
			op_q     <= CHIP_OP_DEFAULT;
			amp_q    <= RST_AMP;
			regul_q  <= RST_REGUL;
			drain_q  <= RST_DRAIN_SET;
		end else begin
			if (write_ok && cmd_addr == ADDR_HS_DRV) hs_q <= cmd_data;
			if (write_ok && cmd_addr == ADDR_LS_DRV) ls_q <= cmd_data;
			if (write_ok && cmd_addr == ADDR_TIMING) timing_q <= cmd_data;
			if (write_ok && cmd_addr == ADDR_AMP) amp_q <= cmd_data;
			if (write_ok && cmd_addr == ADDR_REGUL) regul_q <= cmd_data;
			if (write_ok && cmd_addr == ADDR_DRAIN_SET) drain_q <= drain_d;
			op_q <= superv_expire ?
				(op_d & ~(11'h001 << SUPERV_ON_BIT)) : op_d;
		end
	end

	// supervision timer and latched fault; expiry wins over a clear
	// count to the interval, restart on a read of 0x1
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			timer_q        <= 32'h0;
			superv_fault_q <= 1'b0;
		end else begin
			timer_q <= (!superv_on || restart_hit || superv_expire) ?
				32'h0 : timer_q + 32'h1;
			if (superv_expire) begin
				superv_fault_q <= 1'b1;
			end else if (superv_clear) begin
				superv_fault_q <= 1'b0;
			end
		end
	end

	// event outputs, one cycle each except the level fault
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			restart_q   <= 1'b0;
			frame_err_q <= 1'b0;
		end else begin
			restart_q   <= restart_hit;
			frame_err_q <= frame_done && !frame_ok;
		end
	end

	// status words built from the snapshot; the chip word adds the supervision fault
	// drain faults high, reserved 4:3, sense faults low
	// sense faults hidden when those monitors are off
	assign drain_word = {snap_q.drain_oc, 2'b00,
		snap_q.sense_oc & {3{!op_q[SENSE_OFF_BIT]}}};
	// supply and thermal faults hidden when off
	assign chip_word = {
		snap_q.chip[10] && !op_q[SUPPLY_OFF_BIT],
		superv_fault_q,
		snap_q.chip[8] && !op_q[THERMAL_OFF_BIT],
		1'b0, snap_q.chip[6:4], 1'b0, snap_q.chip[2:0]};
	// gate faults hidden when detection is off
	assign gate_word = {snap_q.gate_fault & {6{!op_q[GATE_OFF_BIT]}},
		5'h00};
	assign any_fault = (|drain_word) || (|chip_word) || (|gate_word);
	// summary fault on top, live drain OR in bit 5
	assign warn_word = {any_fault, 1'b0, snap_q.warn[8:6],
		|snap_q.drain_oc, snap_q.warn[4:0]};

	// read view; unused and reserved slots read zero
	// status words have no write path at all
	always_comb begin
		for (int i = 0; i < 16; i++) begin
			view[i] = 11'h000;
		end
		view[ADDR_WARN]      = warn_word;
		view[ADDR_DRAIN]     = drain_word;
		view[ADDR_CHIP]      = chip_word;
		view[ADDR_GATE]      = gate_word;
		view[ADDR_HS_DRV]    = hs_q;
		view[ADDR_LS_DRV]    = ls_q;
		view[ADDR_TIMING]    = timing_q;
		view[ADDR_CHIP_OP]   = op_q;
		view[ADDR_AMP]       = amp_q;
		view[ADDR_REGUL]     = regul_q;
		view[ADDR_DRAIN_SET] = drain_q;
	end

	// outputs straight from registers
	assign control = '{hs_q, ls_q, timing_q, op_q, amp_q, regul_q, drain_q};
	assign supervision_restart = restart_q;
	assign supervision_fault   = superv_fault_q;
	assign frame_error         = frame_err_q;

endmodule : gate_port

// >>> verilog/gate_port_pkg.sv
// package: constants and carrier types for the gate driver serial register port
package gate_port_pkg;

	// frame layout
	localparam int         WORD_W      = 16;
	localparam int         DATA_W      = 11;
	localparam int         ADDR_W      = 4;
	localparam int         RW_BIT      = 15;
	localparam int         ADDR_HI     = 14;
	localparam int         ADDR_LO     = 11;
	localparam logic [4:0] FRAME_BITS  = 5'h10;
	localparam logic [4:0] HEAD_BITS   = 5'h05;
	localparam logic [4:0] COUNT_MAX   = 5'h1f;

	// register addresses
	localparam logic [3:0] ADDR_WARN     = 4'h1;
	localparam logic [3:0] ADDR_DRAIN    = 4'h2;
	localparam logic [3:0] ADDR_CHIP     = 4'h3;
	localparam logic [3:0] ADDR_GATE     = 4'h4;
	localparam logic [3:0] ADDR_HS_DRV   = 4'h5;
	localparam logic [3:0] ADDR_LS_DRV   = 4'h6;
	localparam logic [3:0] ADDR_TIMING   = 4'h7;
	localparam logic [3:0] ADDR_UNUSED   = 4'h8;
	localparam logic [3:0] ADDR_CHIP_OP  = 4'h9;
	localparam logic [3:0] ADDR_AMP      = 4'ha;
	localparam logic [3:0] ADDR_REGUL    = 4'hb;
	localparam logic [3:0] ADDR_DRAIN_SET = 4'hc;

	// chip operation field positions
	localparam int THERMAL_OFF_BIT = 10;
	localparam int SUPPLY_OFF_BIT  = 9;
	localparam int GATE_OFF_BIT    = 8;
	localparam int SUPERV_DLY_HI   = 6;
	localparam int SUPERV_DLY_LO   = 5;
	localparam int SENSE_OFF_BIT   = 4;
	localparam int SUPERV_ON_BIT   = 3;
	localparam int FAULT_CLR_BIT   = 1;

	// status field positions
	localparam int SUM_FAULT_BIT   = 10;
	localparam int LIVE_OR_BIT     = 5;
	localparam int CHIP_SUPPLY_BIT = 10;
	localparam int CHIP_SUPERV_BIT = 9;
	localparam int CHIP_THERMAL_BIT = 8;

	// drain monitor mode field and codes
	localparam int         MODE_HI       = 2;
	localparam logic [2:0] MODE_LATCHED  = 3'h0;
	localparam logic [2:0] MODE_REPORT   = 3'h1;
	localparam logic [2:0] MODE_DISABLED = 3'h2;

	// control register values after reset and after sleep
	localparam logic [10:0] RST_HS_DRV    = 11'h344;
	localparam logic [10:0] RST_LS_DRV    = 11'h344;
	localparam logic [10:0] RST_TIMING    = 11'h000;
	localparam logic [10:0] RST_CHIP_OP   = 11'h000;
	localparam logic [10:0] RST_AMP       = 11'h000;
	localparam logic [10:0] RST_REGUL     = 11'h000;
	localparam logic [10:0] RST_DRAIN_SET = 11'h000;

	// raw monitor levels from the analog side
	typedef struct packed {
		logic [10:0] warn;        // bits 10, 9 and 5 unused
		logic [5:0]  drain_oc;    // high a, low a, high b, low b, high c, low c
		logic [2:0]  sense_oc;    // phase c, b, a
		logic [10:0] chip;        // bits 9, 7 and 3 unused, bit 9 supplied by the supervision fault
		logic [5:0]  gate_fault;  // same order as drain_oc
	} status_in_t;

	// settings handed to the drive logic
	typedef struct packed {
		logic [10:0] high_side_drive;
		logic [10:0] low_side_drive;
		logic [10:0] drive_timing;
		logic [10:0] chip_operation;
		logic [10:0] current_amp;
		logic [10:0] regulator;
		logic [10:0] drain_sense;
	} control_t;

endpackage : gate_port_pkg
